// File: bsr_pkg.sv
package bsr_pkg;
    // instruction register and opcodes
    localparam int         IR_W        = 4;
    localparam logic [3:0] OP_SAMPLE   = 4'h2;
    localparam logic [3:0] OP_RESET    = 4'hc;
    localparam logic [3:0] OP_BYPASS   = 4'hf;
    localparam logic [3:0] IR_DEFAULT  = 4'hf;
    localparam logic [3:0] IR_CAPTURE  = 4'h1;

    // apb register map, one aligned word
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] CTL_ADDR    = 8'h00;
    localparam int         CTL_DIS_BIT = 7;
    localparam int         CTL_FLG_BIT = 4;
    localparam logic [7:0] CTL_RESET   = 8'h00;

    // timing counts in pclk cycles
    localparam int         WIN_CYC     = 4;
    localparam int         RST_TMO_DEF = 64;

    // chain layout: three cells per pin, then the extra cells
    localparam int PIN_CELLS = 3;
    localparam int CELL_PUE  = 0;
    localparam int CELL_OC   = 1;
    localparam int CELL_ODID = 2;
    localparam int X_TW      = 0;
    localparam int X_RSTLO   = 2;
    localparam int X_RESET_HIGHVOLT_OBS   = 3;
    localparam int X_OSCEN   = 4;
    localparam int X_CRYSTAL_OSC_CLOCK   = 9;
    localparam int X_CMP     = 14;
    localparam int X_W       = 18;

    // oscillator lines, ext is bit 0; idle clock level per line
    typedef struct packed {
        logic timer;
        logic lowf;
        logic rc;
        logic xtal;
        logic ext;
    } bsr_osc_s;
    localparam logic [4:0] OSC_IDLE = 5'h04;

    // comparator boundary signals, off is bit 0
    typedef struct packed {
        logic bandgap_sel;
        logic mux_sel;
        logic result;
        logic off;
    } bsr_cmp_s;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } bsr_tap_e;
endpackage

// File: bsr_chain.sv
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// RL1: sample/preload captures pins, shifts, updates latches only, pins untouched
// RL2: opcode c selects one-bit chip-reset register; tap not reset by it
// RL3: chip held in reset while reset register holds one, unlatched
// RL4: opcode f selects bypass stage; captures zero, shifts in shift-dr
// RL5: disable bit set turns port off; clear needs programmed fuse
// RL6: disable bit changes only on two equal writes within four cycles
// RL7: software should set disable bit when no tester is attached
// RL8: reset flag set by scan reset; cleared by power-on or zero write
// RL9: each pin has pull-up cell plus two-stage control/data cell
// RL10: input is pin level, data port bit, control direction, pull-up expr
// RL11: alternate functions sit outside cells; chain sees real pin
// RL12: two-wire pins get extra cell for slew-limited driver enable
// RL13: tester must not assert control and two-wire enable together
// RL14: no scan cell for two-wire spike filter
// RL15: reset pin has observe cells for low reset and high voltage
// RL16: each external oscillator has enable cell and observed clock
// RL17: unused clock reads zero, except external rc which reads one
// RL18: tester enables at most one main clock source at a time
// RL19: cap fuse not scannable; crystal runs only if fuse programmed
// RL20: comparator exposes off, result, mux select, bandgap cells
// RL21: all scan registers shift least significant bit first
// RL22: reset register acts as pin low; time-out follows release
// RL23: double-write window counted in pclk cycles, expires if missed
module bsr_chain #(
    parameter int NPINS       = 8,
    parameter int RST_TMO_CYC = bsr_pkg::RST_TMO_DEF
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [bsr_pkg::ADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    output logic                            tdo,
    output logic                            tdo_oe_n,
    input  wire logic                       test_port_fuse,
    input  wire logic [NPINS-1:0]           pin_in_value,
    input  wire logic [NPINS-1:0]           direction_bit,
    input  wire logic [NPINS-1:0]           port_out_bit,
    input  wire logic                       global_pullup_off,
    input  wire logic [1:0]                 twowire_drive_enable,
    input  wire logic                       reset_pin_n,
    input  wire logic                       reset_highvolt,
    input  wire bsr_pkg::bsr_osc_s          osc_enable,
    input  wire bsr_pkg::bsr_osc_s          osc_clock,
    input  wire logic                       internal_cap_fuse,
    input  wire bsr_pkg::bsr_cmp_s          cmp_in,
    output logic [3*NPINS+17:0]             scan_latch,
    output logic                            chip_reset_n,
    output logic                            test_port_active
);
    import bsr_pkg::*;

    localparam int CW  = PIN_CELLS*NPINS + X_W;
    localparam int SW  = NPINS + 11;
    localparam int TMW = $clog2(RST_TMO_CYC + 1);
    localparam logic [TMW-1:0] TMO_LOAD = TMW'(RST_TMO_CYC);
    localparam logic [2:0]     WIN_LOAD = 3'(WIN_CYC);

    if (NPINS < 1 || RST_TMO_CYC < 2) begin : g_chk
        $error("bsr_chain: NPINS must be >= 1 and RST_TMO_CYC >= 2");
    end

    // ---------------- input synchronisers ----------------
    logic [SW-1:0] raw;
    logic [SW-1:0] s1_q, s2_q;
    logic          tck_prev_q;
    // all pin-side levels cross together; only s2_q is read by logic
    assign raw = {cmp_in.result, osc_clock, reset_highvolt, reset_pin_n,
                  pin_in_value, tdi, tms, tck};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q       <= '0;
            s2_q       <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            s1_q       <= raw;
            s2_q       <= s1_q;
            tck_prev_q <= s2_q[0];
        end
    end

    logic           tck_rise, tck_fall, tms_s, tdi_s;
    logic [NPINS-1:0] pin_s;
    bsr_osc_s       ck_s;
    assign tck_rise = s2_q[0] & ~tck_prev_q;
    assign tck_fall = ~s2_q[0] & tck_prev_q;
    assign tms_s    = s2_q[1];
    assign tdi_s    = s2_q[2];
    assign pin_s    = s2_q[3 +: NPINS];
    assign ck_s     = s2_q[NPINS+5 +: 5];

    // ---------------- capture vector ----------------
    logic [CW-1:0] cap;
    localparam int XB = PIN_CELLS*NPINS;
    // RL9: three cells per pin
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        // RL10: pull-up, control and input sources
        assign cap[PIN_CELLS*i+CELL_PUE]  = ~global_pullup_off &
                                            ~direction_bit[i] &
                                            port_out_bit[i];
        assign cap[PIN_CELLS*i+CELL_OC]   = direction_bit[i];
        // RL11: real pin level, alternate functions outside
        assign cap[PIN_CELLS*i+CELL_ODID] = pin_s[i];
    end

    bsr_osc_s osc_obs;
    // RL17: idle clock levels; rc idles high
    always_comb begin
        osc_obs = bsr_osc_s'(OSC_IDLE);
        if (osc_enable.ext)   osc_obs.ext   = ck_s.ext;
        // RL19: crystal needs the cap fuse to run
        if (osc_enable.xtal && internal_cap_fuse)
            osc_obs.xtal = ck_s.xtal;
        if (osc_enable.rc)    osc_obs.rc    = ck_s.rc;
        if (osc_enable.lowf)  osc_obs.lowf  = ck_s.lowf;
        if (osc_enable.timer) osc_obs.timer = ck_s.timer;
    end

    // RL12: two-wire enable cells
    // RL14: no cell for the spike filter; pin cells cover it
    assign cap[XB+X_TW +: 2]  = twowire_drive_enable;
    // RL15: observe-only reset pin cells
    assign cap[XB+X_RSTLO]    = s2_q[NPINS+3];
    assign cap[XB+X_RESET_HIGHVOLT_OBS]    = s2_q[NPINS+4];
    // RL16: oscillator enables and observed clocks
    assign cap[XB+X_OSCEN +: 5] = osc_enable;
    assign cap[XB+X_CRYSTAL_OSC_CLOCK +: 5] = osc_obs;
    // RL20: comparator boundary cells
    assign cap[XB+X_CMP +: 4] = {cmp_in.bandgap_sel, cmp_in.mux_sel,
                                 s2_q[NPINS+10], cmp_in.off};

    // ---------------- tap controller and data registers ----------------
    bsr_tap_e        tap_q, tap_d;
    logic [IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
    logic [CW-1:0]   dr_q, dr_d, lat_q, lat_d;
    logic            bp_q, bp_d, rst_reg_q, rst_reg_d;
    logic            tdo_q, tdo_d, oen_q, oen_d;
    logic            jtd_q, port_en;

    // RL5: port on only with fuse and disable bit clear
    assign port_en = test_port_fuse & ~jtd_q;

    function automatic bsr_tap_e tap_next(bsr_tap_e s, logic m);
        case (s)
            TLR:     tap_next = m ? TLR    : RTI;
            RTI:     tap_next = m ? SEL_DR : RTI;
            SEL_DR:  tap_next = m ? SEL_IR : CAP_DR;
            CAP_DR:  tap_next = m ? EX1_DR : SH_DR;
            SH_DR:   tap_next = m ? EX1_DR : SH_DR;
            EX1_DR:  tap_next = m ? UP_DR  : PA_DR;
            PA_DR:   tap_next = m ? EX2_DR : PA_DR;
            EX2_DR:  tap_next = m ? UP_DR  : SH_DR;
            UP_DR:   tap_next = m ? SEL_DR : RTI;
            SEL_IR:  tap_next = m ? TLR    : CAP_IR;
            CAP_IR:  tap_next = m ? EX1_IR : SH_IR;
            SH_IR:   tap_next = m ? EX1_IR : SH_IR;
            EX1_IR:  tap_next = m ? UP_IR  : PA_IR;
            PA_IR:   tap_next = m ? EX2_IR : PA_IR;
            EX2_IR:  tap_next = m ? UP_IR  : SH_IR;
            UP_IR:   tap_next = m ? SEL_DR : RTI;
            default: tap_next = TLR;
        endcase
    endfunction

    // shifting on tck rise, updates and tdo on tck fall
    always_comb begin
        tap_d     = tap_q;
        ir_d      = ir_q;
        irs_d     = irs_q;
        dr_d      = dr_q;
        lat_d     = lat_q;
        bp_d      = bp_q;
        rst_reg_d = rst_reg_q;
        tdo_d     = tdo_q;
        oen_d     = oen_q;
        if (!port_en) begin
            tap_d = TLR;
            ir_d  = IR_DEFAULT;
            oen_d = 1'b1;
        end else if (tck_rise) begin
            tap_d = tap_next(tap_q, tms_s);
            case (tap_q)
                TLR:    ir_d  = IR_DEFAULT;
                CAP_IR: irs_d = IR_CAPTURE;
                // RL21: lsb first out, tdi enters at msb
                SH_IR:  irs_d = {tdi_s, irs_q[IR_W-1:1]};
                CAP_DR: begin
                    // RL1: snapshot of pins and signals
                    if (ir_q == OP_SAMPLE) dr_d = cap;
                    // RL4: bypass captures zero
                    else if (ir_q != OP_RESET) bp_d = 1'b0;
                end
                SH_DR: begin
                    // RL21: chain shifts lsb first
                    if (ir_q == OP_SAMPLE) dr_d = {tdi_s, dr_q[CW-1:1]};
                    // RL2: one-bit reset register shifted
                    else if (ir_q == OP_RESET) rst_reg_d = tdi_s;
                    else bp_d = tdi_s;
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            oen_d = 1'b1;
            case (tap_q)
                SH_IR: begin
                    tdo_d = irs_q[0];
                    oen_d = 1'b0;
                end
                SH_DR: begin
                    oen_d = 1'b0;
                    if (ir_q == OP_SAMPLE)     tdo_d = dr_q[0];
                    else if (ir_q == OP_RESET) tdo_d = rst_reg_q;
                    else                       tdo_d = bp_q;
                end
                UP_IR: ir_d = irs_q;
                // RL1: latches only, never driven onto pins
                UP_DR: if (ir_q == OP_SAMPLE) lat_d = dr_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_q     <= TLR;
            ir_q      <= IR_DEFAULT;
            irs_q     <= '0;
            dr_q      <= '0;
            lat_q     <= '0;
            bp_q      <= 1'b0;
            rst_reg_q <= 1'b0;
            tdo_q     <= 1'b0;
            oen_q     <= 1'b1;
        end else begin
            tap_q     <= tap_d;
            ir_q      <= ir_d;
            irs_q     <= irs_d;
            dr_q      <= dr_d;
            lat_q     <= lat_d;
            bp_q      <= bp_d;
            rst_reg_q <= rst_reg_d;
            tdo_q     <= tdo_d;
            oen_q     <= oen_d;
        end
    end

    assign tdo              = tdo_q;
    assign tdo_oe_n         = oen_q;
    assign scan_latch       = lat_q;
    assign test_port_active = port_en;

    // ---------------- chip reset and time-out ----------------
    logic [TMW-1:0] tmo_q, tmo_d;
    // RL22: time-out reloads while held, counts after release
    always_comb begin
        tmo_d = tmo_q;
        if (rst_reg_q)         tmo_d = TMO_LOAD;
        else if (tmo_q != '0)  tmo_d = tmo_q - 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tmo_q <= '0;
        else          tmo_q <= tmo_d;
    end

    // RL3: register acts directly, no update latch
    assign chip_reset_n = ~(rst_reg_q | (tmo_q != '0));

    // ---------------- apb control/status register ----------------
    logic       acc, hit, wr;
    logic       jtd_d, pend_q, pend_d, test_reset_flag_q, test_reset_flag_d;
    logic [2:0] win_q, win_d;
    logic [7:0] rd_q, rd_d;
    assign acc     = psel & penable;
    assign hit     = paddr == CTL_ADDR;
    assign wr      = acc & pwrite & hit;
    assign pready  = 1'b1;            // zero wait states
    assign pslverr = acc & ~hit;

    always_comb begin
        jtd_d  = jtd_q;
        pend_d = pend_q;
        test_reset_flag_d = test_reset_flag_q;
        rd_d   = rd_q;
        // RL23: window counts down in pclk cycles
        win_d  = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
        if (wr) begin
            // RL6: second equal write inside window commits
            if (win_q != 3'h0 && pwdata[CTL_DIS_BIT] == pend_q) begin
                jtd_d = pend_q;
                win_d = 3'h0;
            end else begin
                pend_d = pwdata[CTL_DIS_BIT];
                win_d  = WIN_LOAD;
            end
            if (!pwdata[CTL_FLG_BIT]) test_reset_flag_d = 1'b0;
        end
        // RL8: set wins over a clearing write
        if (rst_reg_q) test_reset_flag_d = 1'b1;
        if (psel && !penable && !pwrite && hit) begin
            rd_d = CTL_RESET;
            rd_d[CTL_DIS_BIT] = jtd_q;
            rd_d[CTL_FLG_BIT] = test_reset_flag_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jtd_q  <= CTL_RESET[CTL_DIS_BIT];
            pend_q <= 1'b0;
            test_reset_flag_q <= CTL_RESET[CTL_FLG_BIT];
            win_q  <= 3'h0;
            rd_q   <= CTL_RESET;
        end else begin
            jtd_q  <= jtd_d;
            pend_q <= pend_d;
            test_reset_flag_q <= test_reset_flag_d;
            win_q  <= win_d;
            rd_q   <= rd_d;
        end
    end

    // unmapped reads return zero
    assign prdata = hit ? {24'h000000, rd_q} : 32'h00000000;

    // ---------------- assertions ----------------
    property p_rst_hold;
        @(posedge pclk) disable iff (!presetn)
        rst_reg_q |-> !chip_reset_n;
    endproperty
    a_rst_hold: assert property (p_rst_hold) // RL3
        else $error("chip reset released while reset register set");

    property p_rst_shift;
        @(posedge pclk) disable iff (!presetn)
        (tck_rise && port_en && tap_q == SH_DR && ir_q == OP_RESET)
        |=> rst_reg_q == $past(tdi_s);
    endproperty
    a_rst_shift: assert property (p_rst_shift) // RL2
        else $error("reset register did not take tdi");

    property p_bp_cap;
        @(posedge pclk) disable iff (!presetn)
        (tck_rise && port_en && tap_q == CAP_DR && ir_q == OP_BYPASS)
        |=> !bp_q;
    endproperty
    a_bp_cap: assert property (p_bp_cap) // RL4
        else $error("bypass did not capture zero");

    property p_dis_tlr;
        @(posedge pclk) disable iff (!presetn)
        !port_en |=> tap_q == TLR && tdo_oe_n;
    endproperty
    a_dis_tlr: assert property (p_dis_tlr) // RL5
        else $error("disabled port still active");

    property p_single_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr && win_q == 3'h0) |=> jtd_q == $past(jtd_q);
    endproperty
    a_single_wr: assert property (p_single_wr) // RL6
        else $error("single write changed disable bit");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        rst_reg_q |=> test_reset_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) // RL8
        else $error("reset flag not set by scan reset");

    property p_tmo;
        @(posedge pclk) disable iff (!presetn)
        $fell(rst_reg_q) |-> !chip_reset_n [*2];
    endproperty
    a_tmo: assert property (p_tmo) // RL22
        else $error("reset time-out skipped after release");

    property p_update;
        @(posedge pclk) disable iff (!presetn)
        (tck_fall && port_en && tap_q == UP_DR && ir_q == OP_SAMPLE)
        |=> scan_latch == $past(dr_q);
    endproperty
    a_update: assert property (p_update) // RL1
        else $error("update did not load latches");

    property p_lsb;
        @(posedge pclk) disable iff (!presetn)
        (tck_rise && port_en && tap_q == SH_DR && ir_q == OP_SAMPLE)
        |=> dr_q[CW-1] == $past(tdi_s) && dr_q[CW-2:0] == $past(dr_q[CW-1:1]);
    endproperty
    a_lsb: assert property (p_lsb) // RL21
        else $error("chain did not shift lsb first");

    c_reset: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(rst_reg_q));
    c_jtd: cover property (@(posedge pclk) disable iff (!presetn)
        $changed(jtd_q));
    c_update: cover property (@(posedge pclk) disable iff (!presetn)
        tck_fall && tap_q == UP_DR && ir_q == OP_SAMPLE);
    c_bypass: cover property (@(posedge pclk) disable iff (!presetn)
        tck_rise && tap_q == SH_DR && ir_q == OP_BYPASS);
endmodule

// File: bsr_tester.sv
`timescale 1ns/1ps
// link-side tester: owns the test clock, which rests low between frames
module bsr_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    realtime t_shift;

    // idle levels before the first frame
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        t_shift = 0;
    end

    // one 200 ns period; tdo is taken just before the rising edge
    task automatic tick(input logic m, input logic d, input bit sh,
                        output logic o);
        tms = m;
        // released data line toggles so a stale level never looks valid
        tdi = sh ? d : ~tdi;
        #100;
        o = tdo;
        tck = 1'b1;
        if (sh)
            t_shift = $realtime;
        #100;
        tck = 1'b0;
    endtask

    // park in reset, then load an opcode and settle in run-test/idle
    task automatic shift_ir(input logic [3:0] op);
        logic       o;
        logic [9:0] walk;
        walk = 10'b0011011111;
        for (int i = 0; i < 10; i++)
            tick(walk[i], 1'b0, 0, o);
        for (int i = 0; i < 4; i++)
            tick(i == 3, op[i], 1, o);
        tick(1'b1, 1'b0, 0, o);
        tick(1'b0, 1'b0, 0, o);
    endtask

    // data scan from run-test/idle back to run-test/idle
    task automatic shift_dr(input int n, input logic [63:0] d,
                            output logic [63:0] q);
        logic o;
        q = '0;
        tick(1'b1, 1'b0, 0, o);
        tick(1'b0, 1'b0, 0, o);
        tick(1'b0, 1'b0, 0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, d[i], 1, o);
            q[i] = o;
        end
        tick(1'b1, 1'b0, 0, o);
        tick(1'b0, 1'b0, 0, o);
    endtask
endmodule

// File: bsr_chain_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("MISMATCH t=%0t %s", $time, msg); \
        end \
    end
module bsr_chain_bench;
    import bsr_pkg::*;
    localparam int NP  = 2;
    localparam int L   = 3 * NP + 18;
    localparam int TMO = 40;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          er, tck, tms, tdi, tdo, tdo_oe_n, oe_seen;
    logic          fuse, gpo, rst_pin_n, hv, cap, chip_reset_n, active;
    logic [NP-1:0] pin, dir, port;
    logic [1:0]    twe;
    bsr_osc_s      osc_en, osc_ck;
    bsr_cmp_s      cmp;
    logic [L-1:0]  latch;
    logic [63:0]   din, dout;
    int            err_total, n_compared;
    int            seed = 32'h2a228940;

    bsr_chain #(.NPINS(NP), .RST_TMO_CYC(TMO)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .test_port_fuse(fuse), .pin_in_value(pin), .direction_bit(dir),
        .port_out_bit(port), .global_pullup_off(gpo),
        .twowire_drive_enable(twe), .reset_pin_n(rst_pin_n),
        .reset_highvolt(hv), .osc_enable(osc_en), .osc_clock(osc_ck),
        .internal_cap_fuse(cap), .cmp_in(cmp), .scan_latch(latch),
        .chip_reset_n(chip_reset_n), .test_port_active(active));

    bsr_tester tester_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
                         .tdo_oe_n(tdo_oe_n));

    // 40 MHz system clock
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    // remembers whether the port ever drove its data output
    always @(posedge pclk)
        if (tdo_oe_n === 1'b0)
            oe_seen <= 1'b1;

    // zero wait states expected, but the wait is bounded at 100 cycles
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input bit last);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100)
            err_total++;
        rd = prdata;
        er = pslverr;
        if (last) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // expected snapshot of every capture cell
    function automatic logic [L-1:0] exp_cap();
        logic [L-1:0] v;
        logic [4:0]   on;
        v = '0;
        for (int i = 0; i < NP; i++)
            v[3*i+:3] = {pin[i], dir[i], ~gpo & ~dir[i] & port[i]};
        on = osc_en;
        on[1] = osc_en.xtal & cap;
        // idle level of unused clock lines
        for (int k = 0; k < 5; k++)
            v[3*NP+9+k] = on[k] ? osc_ck[k] : OSC_IDLE[k];
        v[3*NP+:9] = {osc_en, hv, rst_pin_n, twe};
        v[3*NP+14+:4] = cmp;
        return v;
    endfunction

    // random pin, clock and comparator levels
    task automatic rand_pins();
        logic [31:0] r;
        r = $random(seed);
        {pin, dir, port} <= r[3*NP-1:0];
        {gpo, rst_pin_n, hv, cap, twe} <= r[3*NP+:6];
        osc_ck <= r[20+:5];
        cmp <= r[25+:4];
        // at most one clock source enabled
        osc_en <= (r[31:29] < 5) ? 5'h01 << r[31:29] : 5'h00;
    endtask

    task automatic t_disable();
        apb(0, CTL_ADDR, 0, 1);
        `CHK(rd, 32'h0, "register reset value")
        `CHK(active, 1'b1, "port on after reset")
        apb(0, 8'h04, 0, 1);
        `CHK({er, rd}, {1'b1, 32'h0}, "unmapped read")
        apb(1, 8'h04, 32'h80, 0);
        apb(1, 8'h04, 32'h80, 1);
        apb(1, CTL_ADDR, 32'h80, 1);
        repeat (6) @(posedge pclk);
        apb(1, CTL_ADDR, 32'h80, 1);
        apb(0, CTL_ADDR, 0, 1);
        `CHK(rd[7], 1'b0, "lone or late write")
        // software parks the port when no tester is attached
        apb(1, CTL_ADDR, 32'h80, 0);
        apb(1, CTL_ADDR, 32'h80, 1);
        apb(0, CTL_ADDR, 0, 1);
        `CHK(rd, 32'h80, "double write")
        `CHK(active, 1'b0, "port off")
        oe_seen = 1'b0;
        tester_u.shift_ir(OP_BYPASS);
        `CHK(oe_seen, 1'b0, "disabled port quiet")
        // tester timing is free-running; realign to pclk before apb
        @(posedge pclk);
        apb(1, CTL_ADDR, 32'h0, 0);
        apb(1, CTL_ADDR, 32'h0, 1);
        fuse <= 1'b0;
        @(negedge pclk);
        `CHK(active, 1'b0, "fuse unprogrammed")
        @(posedge pclk);
        fuse <= 1'b1;
        $display("test disable done");
    endtask

    task automatic t_bypass();
        logic [3:0] ops [2];
        ops = '{OP_BYPASS, 4'h5};
        for (int i = 0; i < 2; i++) begin
            din = {$random(seed), $random(seed)};
            oe_seen = 1'b0;
            tester_u.shift_ir(ops[i]);
            tester_u.shift_dr(9, din, dout);
            `CHK(dout[8:0], {din[7:0], 1'b0}, "bypass")
            `CHK(oe_seen, 1'b1, "port drives out")
        end
        $display("test bypass done");
    endtask

    task automatic t_sample();
        logic [L-1:0] ex;
        for (int it = 0; it < 3; it++) begin
            @(posedge pclk);
            rand_pins();
            din = {$random(seed), $random(seed)};
            // two-wire drivers stay off in preload data
            din[3*NP+:2] = 2'b00;
            repeat (4) @(posedge pclk);
            ex = exp_cap();
            tester_u.shift_ir(OP_SAMPLE);
            tester_u.shift_dr(L, din, dout);
            `CHK(dout[L-1:0], ex, "capture")
            `CHK(latch, din[L-1:0], "preload")
        end
        $display("test sample done");
    endtask

    task automatic t_reset();
        realtime t_up;
        int      n;
        tester_u.shift_ir(OP_RESET);
        tester_u.shift_dr(1, 64'h1, dout);
        `CHK(dout[0], 1'b0, "reset register start")
        `CHK(chip_reset_n, 1'b0, "chip in reset")
        repeat (2 * TMO) @(posedge pclk);
        `CHK(chip_reset_n, 1'b0, "reset holds")
        tester_u.shift_dr(1, 64'h0, dout);
        `CHK(dout[0], 1'b1, "tap kept")
        n = 0;
        while (chip_reset_n !== 1'b1 && n < 4 * TMO) begin
            @(negedge pclk);
            n++;
        end
        t_up = $realtime - tester_u.t_shift;
        `CHK(t_up >= TMO*25.0 && t_up <= (TMO+8)*25.0, 1'b1, "time-out")
        @(posedge pclk);
        apb(0, CTL_ADDR, 0, 1);
        `CHK(rd[4], 1'b1, "flag set")
        apb(1, CTL_ADDR, 0, 1);
        apb(0, CTL_ADDR, 0, 1);
        `CHK(rd[4], 1'b0, "flag cleared")
        $display("test reset done");
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence; reset held for six cycles
    initial begin
        err_total = 0;
        n_compared = 0;
        oe_seen = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pin, dir, port, gpo, twe, hv, cap, osc_en, osc_ck, cmp} = '0;
        {fuse, rst_pin_n} = 2'b11;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_disable();
        t_bypass();
        t_sample();
        t_reset();
        report_and_stop();
    end

    // planned traffic is near 50 us; a hang is cut at 500 us
    initial begin
        #500_000;
        err_total++;
        report_and_stop();
    end
endmodule
